//--- core/qsi_top.sv
// Shortcut routing, event flags and interrupt enables behind an APB slave.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module qsi_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire qsi_pkg::qsi_apb_req_type  apb_req,
  output qsi_pkg::qsi_apb_rsp_type       apb_rsp,
  input  wire qsi_pkg::qsi_dp_type       dp,
  output logic                           stop_task,
  output logic [4:0]                     irq_request
);
  import qsi_pkg::*;

  qsi_top_state_type s;       // Registered state.
  qsi_top_state_type next_s;  // Next state.

  // Accumulator views.
  logic signed [QSI_MOTION_W-1:0] motion_acc;   // Live motion count.
  logic [QSI_DOUBLE_W-1:0]        double_acc;   // Live double count.
  logic signed [QSI_MOTION_W-1:0] motion_snap;  // Motion snapshot.
  logic [QSI_DOUBLE_W-1:0]        double_snap;  // Double snapshot.
  logic                           ovf_ev;       // Overflow pulse.
  logic                           period_done;  // End of a report period.

  // Events of this cycle.
  logic sample_ev;   // A new sample arrived.
  logic report_ev;   // Non-null report ready.
  logic double_ev;   // Doubles seen in the period.
  logic stopped_ev;  // The decoder has halted.

  // Task strobes, from software or from shortcuts.
  logic full_clear;    // Snapshot and clear both.
  logic motion_clear;  // Snapshot and clear motion.
  logic double_clear;  // Snapshot and clear doubles.
  logic stop_req;      // Stop the decoder.

  // Bus decode.
  logic bus_access;  // Access phase under way.
  logic bus_wr;      // Write completes this edge.
  logic wr_one;      // Bit 0 of the write data.

  // Read data for an offset; unmapped offsets return zero.
  function automatic logic [31:0] read_word(input logic [11:0] a, input qsi_top_state_type st,
                                            input logic signed [QSI_MOTION_W-1:0] m,
                                            input logic [QSI_DOUBLE_W-1:0] d,
                                            input logic signed [QSI_MOTION_W-1:0] ms,
                                            input logic [QSI_DOUBLE_W-1:0] ds);
    logic [31:0] w;
    w = 32'h00000000;
    if (a == QSI_OFS_EV_SAMPLE) begin
      w[0] = st.flags[QSI_EV_SAMPLE];
    end else if (a == QSI_OFS_EV_REPORT) begin
      w[0] = st.flags[QSI_EV_REPORT];
    end else if (a == QSI_OFS_EV_OVF) begin
      w[0] = st.flags[QSI_EV_OVF];
    end else if (a == QSI_OFS_EV_DOUBLE) begin
      w[0] = st.flags[QSI_EV_DOUBLE];
    end else if (a == QSI_OFS_EV_STOPPED) begin
      w[0] = st.flags[QSI_EV_STOPPED];
    end else if (a == QSI_OFS_SHORTCUTS) begin
      w[6:0] = st.shortcuts;
    end else if (a == QSI_OFS_INTEN_SET) begin
      w[4:0] = st.inten;
    end else if (a == QSI_OFS_PERIOD) begin
      w[3:0] = st.period;
    end else if (a == QSI_OFS_MOTION) begin
      w = 32'(m);  // Sign extended.
    end else if (a == QSI_OFS_MOTION_SNAP) begin
      w = 32'(ms);
    end else if (a == QSI_OFS_DOUBLE) begin
      w[3:0] = d;
    end else if (a == QSI_OFS_DOUBLE_SNAP) begin
      w[3:0] = ds;
    end
    return w;
  endfunction

  // True when the offset names any register, write-only tasks included.
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == QSI_OFS_TASK_STOP) || (a == QSI_OFS_TASK_FULL) ||
           (a == QSI_OFS_TASK_MOTION) || (a == QSI_OFS_TASK_DOUBLE) ||
           (a == QSI_OFS_EV_SAMPLE) || (a == QSI_OFS_EV_REPORT) ||
           (a == QSI_OFS_EV_OVF) || (a == QSI_OFS_EV_DOUBLE) ||
           (a == QSI_OFS_EV_STOPPED) || (a == QSI_OFS_SHORTCUTS) ||
           (a == QSI_OFS_INTEN_SET) || (a == QSI_OFS_PERIOD) ||
           (a == QSI_OFS_MOTION) || (a == QSI_OFS_MOTION_SNAP) ||
           (a == QSI_OFS_DOUBLE) || (a == QSI_OFS_DOUBLE_SNAP);
  endfunction

  // Accumulators; they see the merged clear strobes in the same cycle.
  qsi_accum u_accum (
    .pclk         (pclk),
    .presetn      (presetn),
    .dp           (dp),
    .motion_clear (motion_clear),
    .double_clear (double_clear),
    .motion_acc   (motion_acc),
    .double_acc   (double_acc),
    .motion_snap  (motion_snap),
    .double_snap  (double_snap),
    .overflow     (ovf_ev)
  );

  // Report period counter.
  qsi_report u_report (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_ready (dp.sample_ready),
    .period       (s.period),
    .period_done  (period_done)
  );

  // Event sources. The period pulse lags the last sample by one edge, so
  // the accumulators already hold that sample when they are tested.
  always_comb begin
    sample_ev = dp.sample_ready;
    report_ev = period_done && (motion_acc != '0);
    double_ev = period_done && (double_acc != '0);
  end

  // Bus decode. A write acts only at the edge where pready is seen high.
  always_comb begin
    bus_access = apb_req.psel && apb_req.penable;
    bus_wr     = bus_access && s.rsp.pready && apb_req.pwrite;
    wr_one     = apb_req.pwdata[0];
  end

  // Shortcut routing. Software tasks and shortcut hits share one strobe,
  // so a task asked twice in a cycle still runs once.
  always_comb begin
    full_clear = (bus_wr && apb_req.paddr == QSI_OFS_TASK_FULL && wr_one) ||
                 (report_ev && s.shortcuts[QSI_LNK_REPORT_FULL]) ||
                 (sample_ev && s.shortcuts[QSI_LNK_SAMPLE_FULL]);
    motion_clear = full_clear ||
                   (bus_wr && apb_req.paddr == QSI_OFS_TASK_MOTION && wr_one) ||
                   (report_ev && s.shortcuts[QSI_LNK_REPORT_MOTION]);
    double_clear = full_clear ||
                   (bus_wr && apb_req.paddr == QSI_OFS_TASK_DOUBLE && wr_one) ||
                   (double_ev && s.shortcuts[QSI_LNK_DOUBLE_DOUBLE]);
    stop_req = (bus_wr && apb_req.paddr == QSI_OFS_TASK_STOP && wr_one) ||
               (sample_ev && s.shortcuts[QSI_LNK_SAMPLE_STOP]) ||
               (report_ev && s.shortcuts[QSI_LNK_REPORT_STOP]) ||
               (double_ev && s.shortcuts[QSI_LNK_DOUBLE_STOP]);
  end

  // Main next-state logic: stop tracking, flags, registers and bus answer.
  always_comb begin
    next_s = s;
    stopped_ev = 1'b0;

    // Stop tracking. The halt input is only trusted after a request, so a
    // decoder that was never started does not raise a stopped event.
    case (s.stop_state)
      QSI_RUNNING: begin
        if (stop_req) begin
          next_s.stop_state = QSI_HALT_WAIT;
        end
      end
      QSI_HALT_WAIT: begin
        if (dp.decoder_halted) begin
          stopped_ev = 1'b1;
          next_s.stop_state = QSI_RUNNING;
        end
      end
      default: begin
        next_s.stop_state = QSI_RUNNING;
      end
    endcase
    next_s.stop_task = stop_req;

    // Register writes.
    if (bus_wr) begin
      if (apb_req.paddr == QSI_OFS_SHORTCUTS) begin
        next_s.shortcuts = apb_req.pwdata[6:0];
      end else if (apb_req.paddr == QSI_OFS_INTEN_SET) begin
        // Ones set, zeros leave the enable as it was.
        next_s.inten = s.inten | apb_req.pwdata[4:0];
      end else if (apb_req.paddr == QSI_OFS_PERIOD) begin
        next_s.period = apb_req.pwdata[3:0];
      end else if (apb_req.paddr == QSI_OFS_EV_SAMPLE) begin
        next_s.flags[QSI_EV_SAMPLE] = wr_one;
      end else if (apb_req.paddr == QSI_OFS_EV_REPORT) begin
        next_s.flags[QSI_EV_REPORT] = wr_one;
      end else if (apb_req.paddr == QSI_OFS_EV_OVF) begin
        next_s.flags[QSI_EV_OVF] = wr_one;
      end else if (apb_req.paddr == QSI_OFS_EV_DOUBLE) begin
        next_s.flags[QSI_EV_DOUBLE] = wr_one;
      end else if (apb_req.paddr == QSI_OFS_EV_STOPPED) begin
        next_s.flags[QSI_EV_STOPPED] = wr_one;
      end
    end

    // Hardware sets come last so an event beats a clear in the same cycle.
    if (sample_ev) begin
      next_s.flags[QSI_EV_SAMPLE] = 1'b1;
    end
    if (report_ev) begin
      next_s.flags[QSI_EV_REPORT] = 1'b1;
    end
    if (ovf_ev) begin
      next_s.flags[QSI_EV_OVF] = 1'b1;
    end
    if (double_ev) begin
      next_s.flags[QSI_EV_DOUBLE] = 1'b1;
    end
    if (stopped_ev) begin
      next_s.flags[QSI_EV_STOPPED] = 1'b1;
    end

    // Requests follow the flags as they stand after this edge.
    next_s.irq = next_s.flags & next_s.inten;

    // One wait state: data is loaded on the first access edge and pready
    // drops again right after the completing edge.
    if (bus_access && !s.rsp.pready) begin
      next_s.rsp.pready  = 1'b1;
      next_s.rsp.pslverr = !is_mapped(apb_req.paddr);
      next_s.rsp.prdata  = apb_req.pwrite ? 32'h00000000 :
                           read_word(apb_req.paddr, s, motion_acc, double_acc,
                                     motion_snap, double_snap);
    end else begin
      next_s.rsp.pready  = 1'b0;
      next_s.rsp.pslverr = 1'b0;
    end
  end

  // State register. Every field, shortcuts and enables included, clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.rsp        <= '0;
      s.shortcuts  <= QSI_SHORTCUT_RESET;
      s.inten      <= QSI_INTEN_RESET;
      s.period     <= QSI_PERIOD_RESET;
      s.flags      <= QSI_FLAG_RESET;
      s.stop_task  <= 1'b0;
      s.irq        <= 5'h00;
      s.stop_state <= QSI_RUNNING;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp     = s.rsp;
  assign stop_task   = s.stop_task;
  assign irq_request = s.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Steps of a stop: request, wait, then the flag.
  sequence stop_asked;
    stop_req && s.stop_state == QSI_RUNNING;
  endsequence
  sequence stopped_seen;
    s.flags[QSI_EV_STOPPED] ##1 1'b1;
  endsequence

  a_report_full_link: assert property (report_ev && s.shortcuts[QSI_LNK_REPORT_FULL] |=>
      motion_snap == $past(motion_acc) && double_snap == $past(double_acc))
    else $error("report link did not snapshot both accumulators");
  a_sample_stop_link: assert property (sample_ev && s.shortcuts[QSI_LNK_SAMPLE_STOP] |=> stop_task)
    else $error("sample link did not stop");
  a_report_motion_clear: assert property (report_ev && s.shortcuts[QSI_LNK_REPORT_MOTION] &&
      !dp.sample_ready |=> motion_acc == 0)
    else $error("report link did not clear motion");
  a_report_stop_link: assert property (report_ev && s.shortcuts[QSI_LNK_REPORT_STOP] |=> stop_task)
    else $error("report link did not stop");
  a_double_clear_link: assert property (double_ev && s.shortcuts[QSI_LNK_DOUBLE_DOUBLE] |=>
      double_snap == $past(double_acc))
    else $error("double link did not snapshot doubles");
  a_double_stop_link: assert property (double_ev && s.shortcuts[QSI_LNK_DOUBLE_STOP] |=> stop_task)
    else $error("double link did not stop");
  a_sample_full_link: assert property (sample_ev && s.shortcuts[QSI_LNK_SAMPLE_FULL] |=>
      motion_snap == $past(motion_acc))
    else $error("sample link did not snapshot motion");
  a_inten_set_bits: assert property (bus_wr && apb_req.paddr == QSI_OFS_INTEN_SET |=>
      (s.inten & $past(apb_req.pwdata[4:0])) == $past(apb_req.pwdata[4:0]))
    else $error("written one did not enable its interrupt");
  a_inten_sticky: assert property (##1 (s.inten & $past(s.inten)) == $past(s.inten))
    else $error("an interrupt enable was lost");
  a_report_gate: assert property (report_ev |-> period_done && motion_acc != 0)
    else $error("report ready without motion");
  a_double_gate: assert property (double_ev |-> double_acc != 0)
    else $error("double ready without doubles");
  a_stop_then_flag: assert property (stop_asked ##1 dp.decoder_halted |-> ##1 stopped_seen)
    else $error("stopped flag missing after halt");

endmodule // qsi_top

//--- core/qsi_pkg.sv
// Package with constants and types for the shortcut and interrupt-enable block.
// Overview of operation
// - Report-ready with link bit triggers full read-clear.
// - Sample-ready with link bit triggers stop.
// - Report-ready with link bit triggers motion read-clear.
// - Report-ready with link bit triggers stop.
// - Double-ready with link bit triggers double read-clear.
// - Double-ready with link bit triggers stop.
// - Writing one enables sample-ready interrupt.
// - Writing one enables report-ready interrupt.
// - Writing one enables overflow interrupt.
// - Writing one enables double-ready interrupt.
// - Writing one enables stopped interrupt.
// - Report-ready needs full period and nonzero motion.
// - Double-ready needs full period and nonzero doubles.
// - Stopped event once decoder halted after stop.
// - Full task snapshots both accumulators, then zeroes.
// - Motion task snapshots motion accumulator, then zeroes.
// - Double task snapshots double accumulator, then zeroes.
package qsi_pkg;

  // Register byte offsets.
  localparam logic [11:0] QSI_OFS_TASK_STOP   = 12'h004;
  localparam logic [11:0] QSI_OFS_TASK_FULL   = 12'h008;
  localparam logic [11:0] QSI_OFS_TASK_MOTION = 12'h00C;
  localparam logic [11:0] QSI_OFS_TASK_DOUBLE = 12'h010;
  localparam logic [11:0] QSI_OFS_EV_SAMPLE   = 12'h100;
  localparam logic [11:0] QSI_OFS_EV_REPORT   = 12'h104;
  localparam logic [11:0] QSI_OFS_EV_OVF      = 12'h108;
  localparam logic [11:0] QSI_OFS_EV_DOUBLE   = 12'h10C;
  localparam logic [11:0] QSI_OFS_EV_STOPPED  = 12'h110;
  localparam logic [11:0] QSI_OFS_SHORTCUTS   = 12'h200;
  localparam logic [11:0] QSI_OFS_INTEN_SET   = 12'h304;
  localparam logic [11:0] QSI_OFS_PERIOD      = 12'h510;
  localparam logic [11:0] QSI_OFS_MOTION      = 12'h514;
  localparam logic [11:0] QSI_OFS_MOTION_SNAP = 12'h518;
  localparam logic [11:0] QSI_OFS_DOUBLE      = 12'h544;
  localparam logic [11:0] QSI_OFS_DOUBLE_SNAP = 12'h548;

  // Shortcut bit positions.
  localparam int QSI_LNK_REPORT_FULL   = 0;
  localparam int QSI_LNK_SAMPLE_STOP   = 1;
  localparam int QSI_LNK_REPORT_MOTION = 2;
  localparam int QSI_LNK_REPORT_STOP   = 3;
  localparam int QSI_LNK_DOUBLE_DOUBLE = 4;
  localparam int QSI_LNK_DOUBLE_STOP   = 5;
  localparam int QSI_LNK_SAMPLE_FULL   = 6;

  // Event positions, shared by flags and interrupt enables.
  localparam int QSI_EV_SAMPLE  = 0;
  localparam int QSI_EV_REPORT  = 1;
  localparam int QSI_EV_OVF     = 2;
  localparam int QSI_EV_DOUBLE  = 3;
  localparam int QSI_EV_STOPPED = 4;

  // Field widths and reset values.
  localparam int QSI_MOTION_W = 11;
  localparam int QSI_DOUBLE_W = 4;
  localparam int QSI_PERIOD_W = 4;
  localparam logic [6:0] QSI_SHORTCUT_RESET = 7'h00;
  localparam logic [4:0] QSI_INTEN_RESET    = 5'h00;
  localparam logic [4:0] QSI_FLAG_RESET     = 5'h00;
  localparam logic [3:0] QSI_PERIOD_RESET   = 4'h0;
  localparam logic [3:0] QSI_COUNT_RESET    = 4'h0;

  // APB request and answer.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } qsi_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } qsi_apb_rsp_type;

  // Inputs from the sampling datapath, all on pclk.
  typedef struct packed {
    logic              sample_ready;
    logic signed [1:0] sample_value;
    logic              double_seen;
    logic              decoder_halted;
  } qsi_dp_type;

  typedef enum logic {QSI_RUNNING, QSI_HALT_WAIT} qsi_stop_state_type;

  typedef struct packed {
    logic signed [QSI_MOTION_W-1:0] motion;
    logic [QSI_DOUBLE_W-1:0]        double_cnt;
    logic signed [QSI_MOTION_W-1:0] motion_snap;
    logic [QSI_DOUBLE_W-1:0]        double_snap;
    logic                           overflow;
  } qsi_accum_state_type;

  typedef struct packed {
    logic [QSI_PERIOD_W-1:0] count;
    logic                    done;
  } qsi_report_state_type;

  typedef struct packed {
    qsi_apb_rsp_type    rsp;
    logic [6:0]         shortcuts;
    logic [4:0]         inten;
    logic [3:0]         period;
    logic [4:0]         flags;
    logic               stop_task;
    logic [4:0]         irq;
    qsi_stop_state_type stop_state;
  } qsi_top_state_type;

endpackage

//--- core/qsi_accum.sv
// Motion and double-transition accumulators with their snapshot registers.
`timescale 1ns/1ps
module qsi_accum (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire qsi_pkg::qsi_dp_type                    dp,
  input  wire logic                                   motion_clear,
  input  wire logic                                   double_clear,
  output logic signed [qsi_pkg::QSI_MOTION_W-1:0]     motion_acc,
  output logic [qsi_pkg::QSI_DOUBLE_W-1:0]            double_acc,
  output logic signed [qsi_pkg::QSI_MOTION_W-1:0]     motion_snap,
  output logic [qsi_pkg::QSI_DOUBLE_W-1:0]            double_snap,
  output logic                                        overflow
);
  import qsi_pkg::*;

  qsi_accum_state_type s;       // Registered state.
  qsi_accum_state_type next_s;  // Next state.
  logic signed [QSI_MOTION_W:0] sum;  // One bit wider to see overflow.

  // A clear copies then zeroes in one edge, so no sample can slip between.
  always_comb begin
    next_s = s;
    next_s.overflow = 1'b0;
    if (motion_clear) begin
      next_s.motion_snap = s.motion;
      next_s.motion = '0;
    end
    if (double_clear) begin
      next_s.double_snap = s.double_cnt;
      next_s.double_cnt = '0;
    end
    // A sample in the clearing cycle lands in the freshly zeroed counter.
    sum = {next_s.motion[QSI_MOTION_W-1], next_s.motion} + (QSI_MOTION_W+1)'(dp.sample_value);
    if (dp.sample_ready) begin
      if (sum[QSI_MOTION_W] != sum[QSI_MOTION_W-1]) begin
        next_s.overflow = 1'b1;  // Overflow: hold the value.
      end else begin
        next_s.motion = sum[QSI_MOTION_W-1:0];
      end
      if (dp.double_seen) begin
        if (&next_s.double_cnt) begin
          next_s.overflow = 1'b1;
        end else begin
          next_s.double_cnt = next_s.double_cnt + 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign motion_acc  = s.motion;
  assign double_acc  = s.double_cnt;
  assign motion_snap = s.motion_snap;
  assign double_snap = s.double_snap;
  assign overflow    = s.overflow;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_motion_snap_copy: assert property (motion_clear |=> motion_snap == $past(motion_acc))
    else $error("motion snapshot does not hold the cleared value");
  a_double_snap_zero: assert property (double_clear && !dp.sample_ready |=> double_acc == 0)
    else $error("double accumulator not zeroed by its task");

endmodule // qsi_accum

//--- core/qsi_report.sv
// Sample counter that marks the end of each report period.
`timescale 1ns/1ps
module qsi_report (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              sample_ready,
  input  wire logic [qsi_pkg::QSI_PERIOD_W-1:0]  period,
  output logic                                   period_done
);
  import qsi_pkg::*;

  qsi_report_state_type s;       // Registered state.
  qsi_report_state_type next_s;  // Next state.

  // A period lasts period+1 samples; done pulses one cycle after the last.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (sample_ready) begin
      if (s.count >= period) begin
        next_s.count = QSI_COUNT_RESET;
        next_s.done = 1'b1;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign period_done = s.done;

endmodule // qsi_report

//--- sim/qsi_top_tb.sv
// Self-checking testbench for the shortcut and interrupt-enable block, with a behavioural model.
`timescale 1ns/1ps
module qsi_top_tb;
  import qsi_pkg::*;

  logic            pclk;        // Bus clock, 40 MHz.
  logic            presetn;     // Active-low asynchronous reset.
  qsi_apb_req_type req;         // APB request driven by the bench.
  qsi_apb_rsp_type apb_rsp;     // APB answer from the design.
  qsi_dp_type      dp;          // Datapath strobes driven by the bench.
  logic            stop_task;   // Stop task pulse from the design.
  logic [4:0]      irq_request; // Interrupt request per event.
  int              errors;      // Mismatches seen.
  int              checked;     // Comparisons made.
  int              stops;       // Stop pulses seen on the port.
  int              xstops;      // Stop pulses the model expects.
  int              ma;          // Model motion accumulator.
  int              da;          // Model double accumulator.
  int              ms;          // Model motion snapshot.
  int              ds;          // Model double snapshot.
  logic [6:0]      sh;          // Model shortcut bits.
  logic [4:0]      fl;          // Model sticky event flags.
  logic [4:0]      ie;          // Model interrupt enables.
  logic [31:0]     rdata;       // Scratch read data.
  logic            err;         // Scratch error flag.

  qsi_top qsi_top_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(apb_rsp),
                     .dp(dp), .stop_task(stop_task), .irq_request(irq_request));

  // Free-running clock with a 25 ns period.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Counting pulses lets merged triggers be told apart from doubled ones.
  always @(posedge pclk) begin
    if (stop_task === 1'b1) stops++;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic e);
    int n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    rd = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdata, err);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h00000000, rdata, err);
    check(nm, rdata, exp);
  endtask

  // Every accumulator and snapshot, the report and double flags, the requests and the stop count against the model.
  task automatic compare_all();
    rd(QSI_OFS_MOTION, 32'(ma), "motion acc");
    rd(QSI_OFS_MOTION_SNAP, 32'(ms), "motion snap");
    rd(QSI_OFS_DOUBLE, 32'(da), "double acc");
    rd(QSI_OFS_DOUBLE_SNAP, 32'(ds), "double snap");
    rd(QSI_OFS_EV_REPORT, 32'(fl[1]), "report flag");
    rd(QSI_OFS_EV_DOUBLE, 32'(fl[3]), "double flag");
    check("irq", 32'(irq_request), 32'(fl & ie));
    check("stops", 32'(stops), 32'(xstops));
  endtask

  // One sample with a period of one sample, so each sample ends a report period.
  task automatic sample(input int v, input logic dbl);
    int   om;
    int   od;
    logic rep;
    logic dr;
    @(posedge pclk);
    dp.sample_ready <= 1'b1;
    dp.sample_value <= 2'(v);
    dp.double_seen <= dbl;
    @(posedge pclk);
    dp.sample_ready <= 1'b0;
    fl[0] = 1'b1;
    if (sh[6]) begin
      ms = ma;
      ds = da;
      ma = v;
      da = int'(dbl);
    end else begin
      ma += v;
      if (da == 15 && dbl) fl[2] = 1'b1;
      else da += int'(dbl);
    end
    om = ma;
    od = da;
    rep = (om != 0);
    dr = (od != 0);
    fl[1] |= rep;
    fl[3] |= dr;
    if (rep && (sh[0] || sh[2])) begin
      ms = om;
      ma = 0;
    end
    if ((rep && sh[0]) || (dr && sh[4])) begin
      ds = od;
      da = 0;
    end
    xstops += int'(sh[1]);
    xstops += int'((rep && sh[3]) || (dr && sh[5]));
    repeat (6) @(posedge pclk);
    compare_all();
  endtask

  initial begin
    presetn = 1'b0;
    req = '0;
    dp = '0;
    {errors, checked, stops, xstops, ma, da, ms, ds} = '0;
    {sh, fl, ie} = '0;
    void'($urandom(32'h1BD953F5));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(QSI_OFS_SHORTCUTS, 32'h00000000, "shortcut reset");
    rd(QSI_OFS_INTEN_SET, 32'h00000000, "enable reset");
    rd(12'h7FC, 32'h00000000, "unmapped data");
    check("unmapped error", 32'(err), 32'h00000001);
    ie = 5'h0A;
    wr(QSI_OFS_INTEN_SET, 32'(ie));
    // Each link alone, then a random mix, so every shortcut bit is exercised.
    for (int r = 0; r < 8; r++) begin
      sh = (r < 7) ? 7'(1 << r) : 7'($urandom);
      wr(QSI_OFS_SHORTCUTS, 32'(sh));
      rd(QSI_OFS_SHORTCUTS, 32'(sh), "shortcuts");
      for (int s = 0; s < 4; s++) sample(int'($urandom_range(2)) - 1, $urandom_range(3) == 0);
    end
    // Enables accumulate; zero writes must leave them alone.
    for (int i = 0; i < 5; i++) begin
      wr(QSI_OFS_INTEN_SET, 32'(1 << i));
      wr(QSI_OFS_INTEN_SET, 32'h00000000);
      ie |= 5'(1 << i);
      rd(QSI_OFS_INTEN_SET, 32'(ie), "enables");
    end
    // Software tasks: a full read-clear snapshots both counters, and a stop pulses once.
    wr(QSI_OFS_TASK_FULL, 32'h00000001);
    ms = ma;
    ds = da;
    ma = 0;
    da = 0;
    wr(QSI_OFS_TASK_STOP, 32'h00000001);
    xstops++;
    repeat (4) @(posedge pclk);
    compare_all();
    // A stop is pending from the earlier links, so a halt must raise the flag.
    dp.decoder_halted <= 1'b1;
    fl[4] = 1'b1;
    repeat (4) @(posedge pclk);
    rd(QSI_OFS_EV_STOPPED, 32'h00000001, "stopped flag");
    compare_all();
    finish_test();
  end
endmodule // qsi_top_tb
